// ### core/dpwm_cfg.svh
// constants for the dual pulse output block: field widths, reset values, timing
// assumes a 200 MHz module clock; includers use the bare file name
`ifndef DPWM_CFG_SVH
`define DPWM_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DPWM_LVL_W 10
`define DPWM_FSEL_W 2
`define DPWM_TMR_W 8
`define DPWM_MAX_LVL 10'h3ff
`define DPWM_HALF_LVL 10'h1ff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPWM_LVL_RST 10'h000
`define DPWM_FSEL0_RST 2'h1
`define DPWM_FSEL1_RST 2'h0
`define DPWM_PT_RST 8'hff
`define DPWM_RP_RST 8'h28
`define DPWM_RP_FOREVER 8'hff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPWM_CLK_PS 5000
`define DPWM_PERIOD_NS 64000
`define DPWM_PERIOD_CYC ((`DPWM_PERIOD_NS * 1000) / `DPWM_CLK_PS)
`define DPWM_TICK_MS 100
`define DPWM_TICK_CYC ((`DPWM_TICK_MS * 1000000) / (`DPWM_CLK_PS / 1000))

`endif

// ### core/dpwm_pkg.sv
// types shared by the dual pulse output block
// assumes nothing beyond the constants header

package dpwm_pkg;
    // ----------------------------------------------------------------
    // setting selectors
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DPWM_SEL_LVL0 = 3'h0,
        DPWM_SEL_LVL1 = 3'h1,
        DPWM_SEL_FSEL0 = 3'h2,
        DPWM_SEL_FSEL1 = 3'h3,
        DPWM_SEL_PT = 3'h4,
        DPWM_SEL_RP = 3'h5
    } dpwm_sel_t;

    typedef enum logic [1:0] {
        DPWM_FN_OFF = 2'h0,
        DPWM_FN_RSSI = 2'h1,
        DPWM_FN_LEVEL = 2'h2
    } dpwm_fn_t;

    typedef struct packed {
        logic wr;
        dpwm_sel_t sel;
        logic [9:0] data;
    } dpwm_cmd_t;

    typedef struct packed {
        logic valid;
        logic src_ok;
        logic [9:0] ad0;
        logic [9:0] ad1;
    } dpwm_sample_t;

    typedef struct packed {
        logic valid;
        logic [9:0] duty;
    } dpwm_rssi_t;
endpackage

// ### core/dpwm_top.sv
// two pulse outputs with host settings, commit step, line passing and rssi hold
// assumes a decoded command stream and received-packet strobes from the module

`timescale 1ns/1ps
`include "dpwm_cfg.svh"

module dpwm_top #(
    parameter int TICK_CYCLES = `DPWM_TICK_CYC,
    parameter int PERIOD_CYCLES = `DPWM_PERIOD_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire dpwm_pkg::dpwm_cmd_t CMD,
    input wire logic CMD_APPLY,
    input wire dpwm_pkg::dpwm_sample_t SAMPLE,
    input wire dpwm_pkg::dpwm_rssi_t RSSI,
    output logic [9:0] RD_DATA,
    output logic PULSE_OUT_ZERO,
    output logic PULSE_OUT_ONE
);
    import dpwm_pkg::*;

    // ----------------------------------------------------------------
    // settings: pending copies written by commands, active after commit
    // ----------------------------------------------------------------
    logic [9:0] pend_lvl [2];
    logic [1:0] pend_fsel [2];
    logic [7:0] pend_pt;
    logic [7:0] pend_rp;
    logic [9:0] act_lvl [2];
    logic [1:0] act_fsel [2];
    logic [7:0] act_pt;
    logic [7:0] act_rp;

    wire fsel_ok = CMD.data[9:2] == 8'h00 && CMD.data[1:0] != 2'h3;
    wire wr_lvl0 = CMD.wr && CMD.sel == DPWM_SEL_LVL0;
    wire wr_lvl1 = CMD.wr && CMD.sel == DPWM_SEL_LVL1;
    wire wr_fsel0 = CMD.wr && CMD.sel == DPWM_SEL_FSEL0 && fsel_ok;
    wire wr_fsel1 = CMD.wr && CMD.sel == DPWM_SEL_FSEL1 && fsel_ok;
    wire wr_pt = CMD.wr && CMD.sel == DPWM_SEL_PT;
    wire wr_rp = CMD.wr && CMD.sel == DPWM_SEL_RP;
    wire load_sample = SAMPLE.valid && SAMPLE.src_ok;
    logic pt_expire;

    wire [9:0] next_rd =
        CMD.sel == DPWM_SEL_LVL0 ? pend_lvl[0] :
        CMD.sel == DPWM_SEL_LVL1 ? pend_lvl[1] :
        CMD.sel == DPWM_SEL_FSEL0 ? {8'h00, pend_fsel[0]} :
        CMD.sel == DPWM_SEL_FSEL1 ? {8'h00, pend_fsel[1]} :
        CMD.sel == DPWM_SEL_PT ? {2'h0, pend_pt} :
        CMD.sel == DPWM_SEL_RP ? {2'h0, pend_rp} : 10'h000;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_lvl[0] <= `DPWM_LVL_RST;
            pend_lvl[1] <= `DPWM_LVL_RST;
            pend_fsel[0] <= `DPWM_FSEL0_RST;
            pend_fsel[1] <= `DPWM_FSEL1_RST;
            pend_pt <= `DPWM_PT_RST;
            pend_rp <= `DPWM_RP_RST;
            RD_DATA <= 10'h000;
        end else begin
            // invalid function codes are dropped, older code stays
            if (wr_lvl0) pend_lvl[0] <= CMD.data;
            else if (load_sample) pend_lvl[0] <= SAMPLE.ad0;
            if (wr_lvl1) pend_lvl[1] <= CMD.data;
            else if (load_sample) pend_lvl[1] <= SAMPLE.ad1;
            if (wr_fsel0) pend_fsel[0] <= CMD.data[1:0];
            if (wr_fsel1) pend_fsel[1] <= CMD.data[1:0];
            if (wr_pt) pend_pt <= CMD.data[7:0];
            if (wr_rp) pend_rp <= CMD.data[7:0];
            RD_DATA <= next_rd;
        end
    end

    // commit wins over a same-cycle sample; the sample still lands in pending
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            act_lvl[0] <= `DPWM_LVL_RST;
            act_lvl[1] <= `DPWM_LVL_RST;
            act_fsel[0] <= `DPWM_FSEL0_RST;
            act_fsel[1] <= `DPWM_FSEL1_RST;
            act_pt <= `DPWM_PT_RST;
            act_rp <= `DPWM_RP_RST;
        end else if (CMD_APPLY) begin
            act_lvl <= pend_lvl;
            act_fsel <= pend_fsel;
            act_pt <= pend_pt;
            act_rp <= pend_rp;
        end else if (load_sample) begin
            act_lvl[0] <= SAMPLE.ad0;
            act_lvl[1] <= SAMPLE.ad1;
        end else if (pt_expire) begin
            act_lvl[0] <= `DPWM_LVL_RST;
            act_lvl[1] <= `DPWM_LVL_RST;
        end
    end

    // ----------------------------------------------------------------
    // 100 ms tick and the two hold timers
    // ----------------------------------------------------------------
    logic [24:0] tick_cnt;
    logic [7:0] pt_cnt;
    logic [7:0] rp_cnt;
    logic pass_live;
    logic rssi_live;
    logic [9:0] rssi_lvl;

    wire tick = tick_cnt == 25'(TICK_CYCLES - 1);
    assign pt_expire = tick && pass_live && pt_cnt == 8'h00 && !load_sample;
    wire rp_expire = tick && rssi_live && act_rp != `DPWM_RP_FOREVER && rp_cnt == 8'h00;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tick_cnt <= 25'h0000000;
            pt_cnt <= 8'h00;
            rp_cnt <= 8'h00;
            pass_live <= 1'b0;
            rssi_live <= 1'b0;
            rssi_lvl <= 10'h000;
        end else begin
            tick_cnt <= tick ? 25'h0000000 : tick_cnt + 25'h0000001;
            if (load_sample) begin
                pt_cnt <= act_pt;
                pass_live <= 1'b1;
            end else if (pt_expire) begin
                pass_live <= 1'b0;
            end else if (tick && pass_live) begin
                pt_cnt <= pt_cnt - 8'h01;
            end
            // zero hold time leaves the indicator dark
            if (RSSI.valid && act_rp != 8'h00) begin
                rp_cnt <= act_rp;
                rssi_live <= 1'b1;
                rssi_lvl <= RSSI.duty;
            end else if (rp_expire) begin
                rssi_live <= 1'b0;
            end else if (tick && rssi_live) begin
                rp_cnt <= rp_cnt - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // period counter and comparators
    // ----------------------------------------------------------------
    logic [13:0] per_cnt;
    logic [1:0] pulse;
    wire [9:0] eff_duty [2];
    wire [1:0] next_pulse;
    wire [23:0] phase = 24'(per_cnt) * 24'd1023;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) per_cnt <= 14'h0000;
        else if (per_cnt == 14'(PERIOD_CYCLES - 1)) per_cnt <= 14'h0000;
        else per_cnt <= per_cnt + 14'h0001;
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            assign eff_duty[i] =
                act_fsel[i] == DPWM_FN_LEVEL ? act_lvl[i] :
                act_fsel[i] == DPWM_FN_RSSI && rssi_live ? rssi_lvl : 10'h000;
            // exact ratio: 0 never high, 3ff high all period
            assign next_pulse[i] = phase < 24'(eff_duty[i]) * 24'(PERIOD_CYCLES);
        end
    endgenerate

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) pulse <= 2'h0;
        else pulse <= next_pulse;
    end
    assign PULSE_OUT_ZERO = pulse[0];
    assign PULSE_OUT_ONE = pulse[1];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_wrap;
        @(posedge CLOCK) disable iff (SYS_RST)
        per_cnt == 14'(PERIOD_CYCLES - 1) |=> per_cnt == 14'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("period did not wrap");

    property p_full;
        @(posedge CLOCK) disable iff (SYS_RST)
        eff_duty[0] == `DPWM_MAX_LVL |=> PULSE_OUT_ZERO;
    endproperty
    a_full: assert property (p_full) else $error("full level not high");

    property p_half;
        @(posedge CLOCK) disable iff (SYS_RST)
        eff_duty[1] == `DPWM_HALF_LVL && per_cnt == 14'(PERIOD_CYCLES / 2 + 2)
        |=> !PULSE_OUT_ONE;
    endproperty
    a_half: assert property (p_half) else $error("half level high too long");

    property p_lvl_wr;
        @(posedge CLOCK) disable iff (SYS_RST)
        wr_lvl0 |=> pend_lvl[0] == $past(CMD.data);
    endproperty
    a_lvl_wr: assert property (p_lvl_wr) else $error("level write lost");

    property p_off;
        @(posedge CLOCK) disable iff (SYS_RST)
        act_fsel[0] == DPWM_FN_OFF |=> !PULSE_OUT_ZERO;
    endproperty
    a_off: assert property (p_off) else $error("disabled output drove high");

    property p_rst_fn;
        @(posedge CLOCK) disable iff (SYS_RST)
        $past(SYS_RST) |-> act_fsel[0] == DPWM_FN_RSSI && act_lvl[0] == 10'h000;
    endproperty
    a_rst_fn: assert property (p_rst_fn) else $error("bad reset settings");

    property p_commit;
        @(posedge CLOCK) disable iff (SYS_RST)
        CMD_APPLY |=> act_fsel[1] == $past(pend_fsel[1]) && act_lvl[1] == $past(pend_lvl[1]);
    endproperty
    a_commit: assert property (p_commit) else $error("commit not taken");

    property p_pass;
        @(posedge CLOCK) disable iff (SYS_RST)
        load_sample && !CMD_APPLY |=> act_lvl[0] == $past(SAMPLE.ad0) && pass_live;
    endproperty
    a_pass: assert property (p_pass) else $error("sample not passed");

    property p_pt;
        @(posedge CLOCK) disable iff (SYS_RST)
        pt_expire && !CMD_APPLY |=> act_lvl[0] == 10'h000 && !pass_live;
    endproperty
    a_pt: assert property (p_pt) else $error("timeout did not zero level");

    property p_rp;
        @(posedge CLOCK) disable iff (SYS_RST)
        rssi_live && act_rp == `DPWM_RP_FOREVER |=> rssi_live;
    endproperty
    a_rp: assert property (p_rp) else $error("permanent rssi dropped");
endmodule

// ### testbench/dpwm_filter_model.sv
// filter seen by both pulse pins: high count per one-period window
// assumes a window of P clocks equals the pulse period

`timescale 1ns/1ps

module dpwm_filter_model #(
    parameter int P = 1023
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin0,
    input wire logic pin1,
    output logic [10:0] avg0,
    output logic [10:0] avg1
);
    logic [10:0] pos;
    logic [10:0] acc0;
    logic [10:0] acc1;
    logic wrap;

    // ------------------------------------------------
    // averaging window
    // ------------------------------------------------
    // free window: a steady waveform gives the same count at any phase
    assign wrap = (pos == 11'(P - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= '0;
            acc0 <= '0;
            acc1 <= '0;
            avg0 <= '0;
            avg1 <= '0;
        end else begin
            pos <= wrap ? '0 : pos + 11'h001;
            acc0 <= wrap ? '0 : acc0 + 11'(pin0);
            acc1 <= wrap ? '0 : acc1 + 11'(pin1);
            if (wrap) begin
                avg0 <= acc0 + 11'(pin0);
                avg1 <= acc1 + 11'(pin1);
            end
        end
    end
endmodule

// ### testbench/test_dual_pwm_output_control.sv
// bench for the dual pulse block: host commands, commit, samples, rssi
// assumes short tick and a period of 1023 clocks, so high count = level

`timescale 1ns/1ps

module test_dual_pwm_output_control;
    import dpwm_pkg::*;
    localparam int P = 1023;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dpwm_cmd_t cmd = '0;
    logic apply = 1'b0;
    dpwm_sample_t smp = '0;
    dpwm_rssi_t rsi = '0;
    logic [9:0] rd;
    logic out0;
    logic out1;
    logic [10:0] avg0;
    logic [10:0] avg1;
    int bad_count = 0;
    int checks = 0;

    always #2.5 clk = ~clk;

    // short tick so an ff hold can be told apart from 255 ticks in a bounded run
    dpwm_top #(.TICK_CYCLES(20), .PERIOD_CYCLES(P)) uut (
        .CLOCK(clk), .SYS_RST(rst), .CMD(cmd), .CMD_APPLY(apply),
        .SAMPLE(smp), .RSSI(rsi), .RD_DATA(rd),
        .PULSE_OUT_ZERO(out0), .PULSE_OUT_ONE(out1));
    dpwm_filter_model #(.P(P)) filt (.clk(clk), .rst(rst),
        .pin0(out0), .pin1(out1), .avg0(avg0), .avg1(avg1));

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [2:0] s, input logic [9:0] d);
        cmd = '{wr: 1'b1, sel: dpwm_sel_t'(s), data: d};
        @(negedge clk);
        cmd.wr = 1'b0;
        // one idle edge so a following write never re-drives cmd in this step
        @(negedge clk);
    endtask
    task automatic rdsel(input logic [2:0] s);
        cmd.sel = dpwm_sel_t'(s);
        repeat (2) @(negedge clk);
    endtask
    task automatic commit;
        apply = 1'b1;
        @(negedge clk);
        apply = 1'b0;
    endtask
    // one full window after the change has settled
    task automatic meas;
        repeat (2 * P + 4) @(negedge clk);
    endtask
    task automatic pkt(input logic ok, input logic [9:0] a, input logic [9:0] b);
        smp = '{valid: 1'b1, src_ok: ok, ad0: a, ad1: b};
        @(negedge clk);
        smp.valid = 1'b0;
    endtask
    task automatic rf(input logic [9:0] d);
        rsi = '{valid: 1'b1, duty: d};
        @(negedge clk);
        rsi.valid = 1'b0;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        rdsel(3'h0);
        chk({1'b0, rd}, 11'h000);
        rdsel(3'h2);
        chk({1'b0, rd}, 11'h001);
        rdsel(3'h4);
        chk({1'b0, rd}, 11'h0ff);
        rdsel(3'h5);
        chk({1'b0, rd}, 11'h028);
        meas;
        chk(avg0, 11'h000);
    endtask
    task automatic t_rssi;
        // hold of 200 ticks outlasts one measurement
        put(3'h5, 10'h0c8);
        put(3'h3, 10'h001);
        commit;
        rf(10'h155);
        meas;
        chk(avg0, 11'h155);
        chk(avg1, 11'h155);
        put(3'h5, 10'h001);
        commit;
        rf(10'h155);
        repeat (100) @(negedge clk);
        meas;
        chk(avg0, 11'h000);
        put(3'h5, 10'h0ff);
        commit;
        rf(10'h0aa);
        // longer than 256 ticks plus a full window
        repeat (8000) @(negedge clk);
        chk(avg0, 11'h0aa);
        chk(avg1, 11'h0aa);
        put(3'h3, 10'h000);
        commit;
    endtask
    task automatic t_levels;
        logic [9:0] tbl [3] = '{10'h000, 10'h1ff, 10'h3ff};
        put(3'h2, 10'h002);
        foreach (tbl[i]) begin
            put(3'h0, tbl[i]);
            commit;
            meas;
            chk(avg0, {1'b0, tbl[i]});
        end
        put(3'h0, 10'h100);
        meas;
        chk(avg0, 11'h3ff);
        rdsel(3'h0);
        chk({1'b0, rd}, 11'h100);
        commit;
        meas;
        chk(avg0, 11'h100);
    endtask
    task automatic t_chan_one_and_codes;
        put(3'h1, 10'h2aa);
        meas;
        chk(avg1, 11'h000);
        put(3'h3, 10'h002);
        commit;
        meas;
        chk(avg1, 11'h2aa);
        put(3'h1, 10'h1ff);
        commit;
        meas;
        chk(avg1, 11'h1ff);
        put(3'h2, 10'h000);
        commit;
        meas;
        chk(avg0, 11'h000);
        put(3'h2, 10'h003);
        rdsel(3'h2);
        chk({1'b0, rd}, 11'h000);
        put(3'h2, 10'h002);
        commit;
    endtask
    task automatic t_passing;
        pkt(1'b1, 10'h080, 10'h040);
        meas;
        chk(avg0, 11'h080);
        chk(avg1, 11'h040);
        pkt(1'b0, 10'h300, 10'h300);
        meas;
        chk(avg0, 11'h080);
        put(3'h4, 10'h00a);
        commit;
        // resend faster than the 200..220 clock timeout
        repeat (16) begin
            pkt(1'b1, 10'h080, 10'h040);
            repeat (150) @(negedge clk);
        end
        chk(avg0, 11'h080);
        repeat (600) @(negedge clk);
        meas;
        chk(avg0, 11'h000);
        chk(avg1, 11'h000);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_rssi;
        t_levels;
        t_chan_one_and_codes;
        t_passing;
        tally_and_finish;
    end
    // the whole run needs about 40000 clocks
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end
endmodule
